// >>> design/qbp_map.svh
// Address map, reset values and timing counts for the port latch block
`ifndef QBP_MAP_SVH
`define QBP_MAP_SVH
`define QBP_ADDR_PORT0 8'h80
`define QBP_ADDR_PORT1 8'h90
`define QBP_ADDR_PORT2 8'hA0
`define QBP_ADDR_PORT3 8'hB0
`define QBP_ADDR_PORT4 8'hC0
`define QBP_LATCH_RST 8'hFF
`define QBP_FULL_MASK 8'hFF
`define QBP_PORT4_MASK 8'h03
`define QBP_NPORT 5
`define QBP_PIN_W 34
`define QBP_BOOST_CYC 2
`endif

// >>> design/qbp_pad_ctrl.sv
// Pad driver control for one port: pull-down, pull-ups and boost timing
`include "qbp_map.svh"
`default_nettype none
module qbp_pad_ctrl
    import qbp_pkg::*;
#(
    parameter int W = 8,
    parameter bit QUASI = 1'b1,
    parameter bit STRONG_HI = 1'b0,
    parameter bit BUS_BOOST = 1'b0,
    parameter int BOOST_CYC = `QBP_BOOST_CYC
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // drive request in, pad controls out
    qbp_pad_if.pad pif
);
    localparam logic [1:0] CNT_LOAD = 2'(BOOST_CYC - 1);
    logic [W-1:0] prev_r, out_r, oe_r, boost_r, keeper_r, trickle_r;
    logic [1:0] cnt_r [W];
    logic [W-1:0] strong_hi;

    assign strong_hi = {W{STRONG_HI & pif.bus_mode}};

    // registered one edge after the latch, so pins move in the next instruction
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            out_r <= '0;
            oe_r <= '0;
            keeper_r <= '0;
            trickle_r <= '0;
        end else begin
            out_r <= pif.drv & strong_hi;
            oe_r <= ~pif.drv | strong_hi;
            keeper_r <= pif.drv & pif.lvl & {W{QUASI}};
            trickle_r <= pif.drv & {W{QUASI}};
        end
    end

    // prev_r resets high so the reset value itself never fires a boost
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            prev_r <= '1;
            boost_r <= '0;
            for (int i = 0; i < W; i++) begin
                cnt_r[i] <= 2'h0;
            end
        end else begin
            prev_r <= pif.drv;
            for (int i = 0; i < W; i++) begin
                if (QUASI && pif.drv[i] && !prev_r[i]) begin
                    cnt_r[i] <= CNT_LOAD;
                    boost_r[i] <= 1'b1;
                end else if (cnt_r[i] != 2'h0) begin
                    cnt_r[i] <= cnt_r[i] - 2'h1;
                    boost_r[i] <= 1'b1;
                end else begin
                    boost_r[i] <= BUS_BOOST & pif.bus_mode & pif.drv[i];
                end
            end
        end
    end

    assign pif.out = out_r;
    assign pif.oe = oe_r;
    assign pif.boost = boost_r;
    assign pif.keeper = keeper_r;
    assign pif.trickle = trickle_r;
endmodule : qbp_pad_ctrl
`default_nettype wire

// >>> design/qbp_pad_if.sv
// Carrier between the port latch logic and one pad controller
`default_nettype none
interface qbp_pad_if #(
    parameter int W = 8
);
    logic [W-1:0] drv;
    logic bus_mode;
    logic [W-1:0] lvl;
    logic [W-1:0] out;
    logic [W-1:0] oe;
    logic [W-1:0] boost;
    logic [W-1:0] keeper;
    logic [W-1:0] trickle;
    modport ctl (output drv, output bus_mode, output lvl,
                 input out, input oe, input boost, input keeper, input trickle);
    modport pad (input drv, input bus_mode, input lvl,
                 output out, output oe, output boost, output keeper, output trickle);
endinterface : qbp_pad_if
`default_nettype wire

// >>> design/qbp_pkg.sv
// Shared types and helpers for the port latch block
`include "qbp_map.svh"
`default_nettype none
package qbp_pkg;
    typedef logic [7:0] qbp_byte_t;
    typedef enum logic [5:0] {
        QBP_SEL_NONE = 6'h01,
        QBP_SEL_PORT0 = 6'h02,
        QBP_SEL_PORT1 = 6'h04,
        QBP_SEL_PORT2 = 6'h08,
        QBP_SEL_PORT3 = 6'h10,
        QBP_SEL_PORT4 = 6'h20
    } qbp_sel_t;

    function automatic qbp_sel_t qbp_decode(input logic [7:0] addr);
        case (addr)
            `QBP_ADDR_PORT0: return QBP_SEL_PORT0;
            `QBP_ADDR_PORT1: return QBP_SEL_PORT1;
            `QBP_ADDR_PORT2: return QBP_SEL_PORT2;
            `QBP_ADDR_PORT3: return QBP_SEL_PORT3;
            `QBP_ADDR_PORT4: return QBP_SEL_PORT4;
            default: return QBP_SEL_NONE;
        endcase
    endfunction : qbp_decode

    function automatic qbp_byte_t qbp_bit_merge(input qbp_byte_t v, input logic [2:0] idx,
                                                input logic b);
        qbp_byte_t r;
        r = v;
        r[idx] = b;
        return r;
    endfunction : qbp_bit_merge
endpackage : qbp_pkg
`default_nettype wire

// >>> design/qbp_ports.sv
// Port latch block: five port latches, core access and pad drive selection
`include "qbp_map.svh"
`default_nettype none

// Overview of operation
// - A latch-write strobe loads core write data into the addressed port latch.
// - A latch-read strobe returns the stored latch value, not the pin level.
// - A pin-read strobe returns the synchronised pin levels of the addressed port.
// - Each port line works as input or output independently of its neighbours.
// - Latch one releases the pull-down for input use; latch zero drives low.
// - Ports one, three and four follow the alternate output when latch is one.
// - In external memory cycles ports zero and two drive address/data, not latches.
// - Ports zero and two give no general-purpose output while driving the bus.
// - Port zero drives high only in bus cycles; otherwise it is open-drain.
// - Read-modify-write operations on a port read the latch, never the pin.
// - Bit writes read all eight latch bits and change only the addressed bit.
// - Reset sets every bit of every port latch to one.
// - Port zero floats as input; ports one to four pull up as input.
// - Latches update at the end of the cycle; pins follow one edge later.
// - A zero-to-one latch change on ports one to four boosts for two periods.
// - A one sensed at a quasi-bidirectional pin turns on the keeper pull-up.
// - On ports one to four the trickle pull-up is on whenever the pull-down is off.
// - Port two boost pull-up also helps logic-one outputs in bus cycles.
// - Port four has only two lines with internal pull-ups.
module qbp_ports
    import qbp_pkg::*;
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // core register access
    input wire logic [7:0] sfr_addr,
    input wire logic [7:0] sfr_wdata,
    input wire logic sfr_wr,
    input wire logic sfr_bit_wr,
    input wire logic [2:0] sfr_bit_sel,
    input wire logic sfr_bit_val,
    input wire logic sfr_rd_latch,
    input wire logic sfr_rd_pin,
    output logic [7:0] sfr_rdata,
    output logic sfr_rvalid,
    // external memory bus
    input wire logic ext_cycle,
    input wire logic [7:0] ext_addr_data,
    input wire logic [7:0] ext_addr_hi,
    // alternate function outputs, idle high
    input wire logic [7:0] alt_port1,
    input wire logic [7:0] alt_port3,
    input wire logic [1:0] alt_port4,
    // port 0 pins
    input wire logic [7:0] port0_in,
    output logic [7:0] port0_out,
    output logic [7:0] port0_oe,
    // port 1 pins
    input wire logic [7:0] port1_in,
    output logic [7:0] port1_out,
    output logic [7:0] port1_oe,
    output logic [7:0] port1_transition_boost_pullup,
    output logic [7:0] port1_keeper_pullup,
    output logic [7:0] port1_trickle_pullup,
    // port 2 pins
    input wire logic [7:0] port2_in,
    output logic [7:0] port2_out,
    output logic [7:0] port2_oe,
    output logic [7:0] port2_transition_boost_pullup,
    output logic [7:0] port2_keeper_pullup,
    output logic [7:0] port2_trickle_pullup,
    // port 3 pins
    input wire logic [7:0] port3_in,
    output logic [7:0] port3_out,
    output logic [7:0] port3_oe,
    output logic [7:0] port3_transition_boost_pullup,
    output logic [7:0] port3_keeper_pullup,
    output logic [7:0] port3_trickle_pullup,
    // port 4 pins
    input wire logic [1:0] port4_in,
    output logic [1:0] port4_out,
    output logic [1:0] port4_oe,
    output logic [1:0] port4_transition_boost_pullup,
    output logic [1:0] port4_keeper_pullup,
    output logic [1:0] port4_trickle_pullup,
    // synchronised level of the CAN receive pin
    output logic can_receive_input
);
    // --------------------
    // address decode
    // --------------------
    qbp_sel_t sel;
    logic [2:0] sel_idx;
    logic sel_hit;
    qbp_byte_t lane_mask;
    qbp_byte_t port_latch_reg_r [`QBP_NPORT];
    qbp_byte_t cur_latch;
    qbp_byte_t byte_nxt;
    qbp_byte_t pin_byte;
    qbp_byte_t sfr_rdata_r;
    logic sfr_rvalid_r;
    logic [`QBP_PIN_W-1:0] pin_raw;
    logic [`QBP_PIN_W-1:0] pin_s;
    logic [7:0] drv0, drv1, drv2, drv3;
    logic [1:0] drv4;

    assign sel = qbp_decode(sfr_addr);

    always_comb begin
        sel_hit = 1'b1;
        case (sel)
            QBP_SEL_PORT0: sel_idx = 3'h0;
            QBP_SEL_PORT1: sel_idx = 3'h1;
            QBP_SEL_PORT2: sel_idx = 3'h2;
            QBP_SEL_PORT3: sel_idx = 3'h3;
            QBP_SEL_PORT4: sel_idx = 3'h4;
            default: begin
                sel_idx = 3'h0;
                sel_hit = 1'b0;
            end
        endcase
    end

    // port four keeps two lines; its upper bits are absent and read zero
    assign lane_mask = (sel_idx == 3'h4) ? `QBP_PORT4_MASK : `QBP_FULL_MASK;
    assign cur_latch = port_latch_reg_r[sel_idx] & lane_mask;

    // --------------------
    // latch update
    // --------------------
    always_comb begin
        byte_nxt = cur_latch;
        if (sfr_wr) begin
            byte_nxt = sfr_wdata & lane_mask;
        end else if (sfr_bit_wr) begin
            byte_nxt = qbp_bit_merge(cur_latch, sfr_bit_sel, sfr_bit_val);
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < `QBP_NPORT; i++) begin
                port_latch_reg_r[i] <= `QBP_LATCH_RST;
            end
        end else if (sel_hit && (sfr_wr || sfr_bit_wr)) begin
            port_latch_reg_r[sel_idx] <= byte_nxt;
        end
    end

    // --------------------
    // read path
    // --------------------
    always_comb begin
        case (sel_idx)
            3'h0: pin_byte = pin_s[7:0];
            3'h1: pin_byte = pin_s[15:8];
            3'h2: pin_byte = pin_s[23:16];
            3'h3: pin_byte = pin_s[31:24];
            3'h4: pin_byte = {6'h00, pin_s[33:32]};
            default: pin_byte = 8'h00;
        endcase
    end

    // read data holds until the next read; unmapped addresses answer zero
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            sfr_rdata_r <= 8'h00;
        end else if (sfr_rd_latch) begin
            sfr_rdata_r <= sel_hit ? cur_latch : 8'h00;
        end else if (sfr_rd_pin) begin
            sfr_rdata_r <= sel_hit ? pin_byte : 8'h00;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            sfr_rvalid_r <= 1'b0;
        end else begin
            sfr_rvalid_r <= sfr_rd_latch | sfr_rd_pin;
        end
    end

    assign sfr_rdata = sfr_rdata_r;
    assign sfr_rvalid = sfr_rvalid_r;

    // --------------------
    // pin drive selection
    // --------------------
    // the latch is still written in bus cycles but has no effect until they end
    assign drv0 = ext_cycle ? ext_addr_data : port_latch_reg_r[0];
    assign drv1 = port_latch_reg_r[1] & alt_port1;
    assign drv2 = ext_cycle ? ext_addr_hi : port_latch_reg_r[2];
    assign drv3 = port_latch_reg_r[3] & alt_port3;
    // the receive line only floats for the CAN input with its latch bit at one
    assign drv4 = port_latch_reg_r[4][1:0] & alt_port4;

    assign pin_raw = {port4_in, port3_in, port2_in, port1_in, port0_in};

    qbp_sync #(
        .W(`QBP_PIN_W)
    ) u_sync (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .d(pin_raw),
        .q(pin_s)
    );

    assign can_receive_input = pin_s[33];

    // --------------------
    // pad controllers
    // --------------------
    qbp_pad_if #(.W(8)) pif0 ();
    qbp_pad_if #(.W(8)) pif1 ();
    qbp_pad_if #(.W(8)) pif2 ();
    qbp_pad_if #(.W(8)) pif3 ();
    qbp_pad_if #(.W(2)) pif4 ();

    assign pif0.drv = drv0;
    assign pif1.drv = drv1;
    assign pif2.drv = drv2;
    assign pif3.drv = drv3;
    assign pif4.drv = drv4;
    assign pif0.bus_mode = ext_cycle;
    assign pif1.bus_mode = 1'b0;
    assign pif2.bus_mode = ext_cycle;
    assign pif3.bus_mode = 1'b0;
    assign pif4.bus_mode = 1'b0;
    assign pif0.lvl = pin_s[7:0];
    assign pif1.lvl = pin_s[15:8];
    assign pif2.lvl = pin_s[23:16];
    assign pif3.lvl = pin_s[31:24];
    assign pif4.lvl = pin_s[33:32];

    // port zero: no pull-ups, strong high only on the bus
    qbp_pad_ctrl #(
        .W(8),
        .QUASI(1'b0),
        .STRONG_HI(1'b1),
        .BUS_BOOST(1'b0),
        .BOOST_CYC(`QBP_BOOST_CYC)
    ) u_pad0 (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .pif(pif0)
    );

    qbp_pad_ctrl #(
        .W(8),
        .QUASI(1'b1),
        .STRONG_HI(1'b0),
        .BUS_BOOST(1'b0),
        .BOOST_CYC(`QBP_BOOST_CYC)
    ) u_pad1 (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .pif(pif1)
    );

    qbp_pad_ctrl #(
        .W(8),
        .QUASI(1'b1),
        .STRONG_HI(1'b0),
        .BUS_BOOST(1'b1),
        .BOOST_CYC(`QBP_BOOST_CYC)
    ) u_pad2 (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .pif(pif2)
    );

    qbp_pad_ctrl #(
        .W(8),
        .QUASI(1'b1),
        .STRONG_HI(1'b0),
        .BUS_BOOST(1'b0),
        .BOOST_CYC(`QBP_BOOST_CYC)
    ) u_pad3 (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .pif(pif3)
    );

    qbp_pad_ctrl #(
        .W(2),
        .QUASI(1'b1),
        .STRONG_HI(1'b0),
        .BUS_BOOST(1'b0),
        .BOOST_CYC(`QBP_BOOST_CYC)
    ) u_pad4 (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .pif(pif4)
    );

    assign port0_out = pif0.out;
    assign port0_oe = pif0.oe;
    assign port1_out = pif1.out;
    assign port1_oe = pif1.oe;
    assign port1_transition_boost_pullup = pif1.boost;
    assign port1_keeper_pullup = pif1.keeper;
    assign port1_trickle_pullup = pif1.trickle;
    assign port2_out = pif2.out;
    assign port2_oe = pif2.oe;
    assign port2_transition_boost_pullup = pif2.boost;
    assign port2_keeper_pullup = pif2.keeper;
    assign port2_trickle_pullup = pif2.trickle;
    assign port3_out = pif3.out;
    assign port3_oe = pif3.oe;
    assign port3_transition_boost_pullup = pif3.boost;
    assign port3_keeper_pullup = pif3.keeper;
    assign port3_trickle_pullup = pif3.trickle;
    assign port4_out = pif4.out;
    assign port4_oe = pif4.oe;
    assign port4_transition_boost_pullup = pif4.boost;
    assign port4_keeper_pullup = pif4.keeper;
    assign port4_trickle_pullup = pif4.trickle;

    // --------------------
    // checks
    // --------------------
    default clocking chk_cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_n);

    logic chk_first_r;
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            chk_first_r <= 1'b1;
        end else begin
            chk_first_r <= 1'b0;
        end
    end

    chk_reset_ones: assert property (
        chk_first_r |-> (port_latch_reg_r[0] == `QBP_LATCH_RST)
            && (port_latch_reg_r[3] == `QBP_LATCH_RST))
        else $error("latch not all ones after reset");
    chk_latch_load: assert property (
        sfr_wr && sel == QBP_SEL_PORT1 |=> port_latch_reg_r[1] == $past(sfr_wdata))
        else $error("byte write did not load latch");
    chk_read_latch: assert property (
        sfr_rd_latch && sel == QBP_SEL_PORT2
            |=> sfr_rvalid && sfr_rdata == $past(port_latch_reg_r[2]))
        else $error("latch read returned wrong value");
    chk_read_pin: assert property (
        sfr_rd_pin && !sfr_rd_latch && sel == QBP_SEL_PORT3
            |=> sfr_rvalid && sfr_rdata == $past(pin_s[31:24]))
        else $error("pin read returned wrong value");
    chk_bit_only: assert property (
        sfr_bit_wr && !sfr_wr && sel == QBP_SEL_PORT1
            |=> ((port_latch_reg_r[1] ^ $past(port_latch_reg_r[1]))
                & ~(8'h01 << $past(sfr_bit_sel))) == 8'h00
            && port_latch_reg_r[1][$past(sfr_bit_sel)] == $past(sfr_bit_val))
        else $error("bit write disturbed other bits");
    chk_low_drive: assert property (
        !drv1[0] |=> port1_oe[0] && !port1_out[0])
        else $error("latch zero did not pull low");
    chk_alt_follow: assert property (
        port_latch_reg_r[3][1] && !alt_port3[1] |=> port3_oe[1] && !port3_trickle_pullup[1])
        else $error("pin did not follow alternate output");
    chk_bus_drive: assert property (
        ext_cycle && ext_addr_data[0] |=> port0_oe[0] && port0_out[0])
        else $error("port0 did not drive bus one");
    chk_gpio_blocked: assert property (
        ext_cycle && ext_addr_hi[5] && !port_latch_reg_r[2][5] |=> !port2_oe[5])
        else $error("latch leaked onto bus pin");
    chk_port0_float: assert property (
        !ext_cycle && port_latch_reg_r[0][2] |=> !port0_oe[2] && !port0_out[2])
        else $error("port0 not open-drain");
    chk_input_pullup: assert property (
        drv1[4] |=> port1_trickle_pullup[4] && !port1_oe[4])
        else $error("quasi pin not pulled up as input");
    chk_boost_pair: assert property (
        $rose(drv1[0]) |=> port1_transition_boost_pullup[0] [*2])
        else $error("boost shorter than two periods");
    chk_boost_end: assert property (
        $rose(drv1[0]) ##1 drv1[0] ##1 drv1[0] |=> !port1_transition_boost_pullup[0])
        else $error("boost longer than two periods");
    chk_keeper_on: assert property (
        drv3[2] && pin_s[26] |=> port3_keeper_pullup[2])
        else $error("keeper off with pin high");
    chk_trickle_off: assert property (
        !drv4[0] |=> !port4_trickle_pullup[0] && port4_oe[0])
        else $error("trickle on while pulling low");
    chk_bus_boost: assert property (
        ext_cycle && ext_addr_hi[3] |=> port2_transition_boost_pullup[3])
        else $error("port2 bus one without boost");
    chk_read_pulse: assert property (
        !sfr_rd_latch && !sfr_rd_pin |=> !sfr_rvalid)
        else $error("read valid without a read");

    cov_bit_write: cover property (sfr_bit_wr && sel_hit ##1 sfr_rd_latch);
    cov_bus_cycle: cover property (ext_cycle [*3] ##1 !ext_cycle);
    cov_pin_read: cover property (sfr_rd_pin && sel == QBP_SEL_PORT4);
    cov_boost_run: cover property ($rose(port3_transition_boost_pullup[7]));
endmodule : qbp_ports
`default_nettype wire

// >>> design/qbp_sync.sv
// Two-flop synchroniser for the port pin levels
`default_nettype none
module qbp_sync #(
    parameter int W = 8
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // raw pin levels in, synchronised levels out
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_r;
    logic [W-1:0] sync_r;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_r <= '0;
            sync_r <= '0;
        end else begin
            meta_r <= d;
            sync_r <= meta_r;
        end
    end

    assign q = sync_r;
endmodule : qbp_sync
`default_nettype wire

// >>> dv/qbp_pin_model.sv
// Pin world model: resolves one port's pad controls against an external driver
`default_nettype none
module qbp_pin_model #(
    parameter int W = 8,
    parameter bit PULL = 1'b1
) (
    // clock
    input wire logic clk,
    // pad controls from the block, external driver from the bench
    input wire logic [W-1:0] out,
    input wire logic [W-1:0] oe,
    input wire logic [W-1:0] ext_en,
    input wire logic [W-1:0] ext_val,
    // resolved pin level
    output logic [W-1:0] pin
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [W-1:0] float_r = '0;
    // undriven line without pull-up wanders, so a stale value never passes
    always @(posedge clk) begin
        float_r <= ~float_r;
    end
    always_comb begin
        for (int i = 0; i < W; i++) begin
            if (oe[i]) pin[i] = out[i];
            else if (ext_en[i]) pin[i] = ext_val[i];
            else pin[i] = PULL ? 1'b1 : float_r[i];
        end
    end
endmodule : qbp_pin_model
`default_nettype wire

// >>> dv/qbp_tb.sv
// Self-checking bench for the port latch block
`include "qbp_map.svh"
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk, rst_n, wr, bw, bv, rl, rp, ext, can, rv;
    logic [7:0] adr_s, wd, ea, eh, a1, a3, rdat, d, o0, e0, o1, e1, b1, k1, t1;
    logic [7:0] o2, e2, b2, k2, t2, o3, e3, b3, k3, t3, p0, p1, p2, p3;
    logic [2:0] bs;
    logic [1:0] a4, o4, e4, b4, k4, t4, p4;
    logic [4:0][7:0] xe, xv;
    logic [31:0] seed = 32'h0000_377E;
    int fails, compares, cyc;
    int lat [5];
    logic [7:0] adr [5] = '{`QBP_ADDR_PORT0, `QBP_ADDR_PORT1, `QBP_ADDR_PORT2,
                            `QBP_ADDR_PORT3, `QBP_ADDR_PORT4};
    logic [7:0] msk [5] = '{8'hFF, 8'hFF, 8'hFF, 8'hFF, `QBP_PORT4_MASK};
    // ----------------------------------------
    // design and pin world
    // ----------------------------------------
    qbp_ports DUT (.sys_clk(sys_clk), .rst_n(rst_n), .sfr_addr(adr_s), .sfr_wdata(wd),
        .sfr_wr(wr), .sfr_bit_wr(bw), .sfr_bit_sel(bs), .sfr_bit_val(bv),
        .sfr_rd_latch(rl), .sfr_rd_pin(rp), .sfr_rdata(rdat), .sfr_rvalid(rv),
        .ext_cycle(ext), .ext_addr_data(ea), .ext_addr_hi(eh), .alt_port1(a1),
        .alt_port3(a3), .alt_port4(a4), .port0_in(p0), .port0_out(o0), .port0_oe(e0),
        .port1_in(p1), .port1_out(o1), .port1_oe(e1), .port1_transition_boost_pullup(b1),
        .port1_keeper_pullup(k1), .port1_trickle_pullup(t1), .port2_in(p2),
        .port2_out(o2), .port2_oe(e2), .port2_transition_boost_pullup(b2),
        .port2_keeper_pullup(k2), .port2_trickle_pullup(t2), .port3_in(p3),
        .port3_out(o3), .port3_oe(e3), .port3_transition_boost_pullup(b3),
        .port3_keeper_pullup(k3), .port3_trickle_pullup(t3), .port4_in(p4),
        .port4_out(o4), .port4_oe(e4), .port4_transition_boost_pullup(b4),
        .port4_keeper_pullup(k4), .port4_trickle_pullup(t4), .can_receive_input(can));
    qbp_pin_model #(.W(8), .PULL(1'b0)) PM0 (.clk(sys_clk), .out(o0), .oe(e0),
        .ext_en(xe[0]), .ext_val(xv[0]), .pin(p0));
    qbp_pin_model PM1 (.clk(sys_clk), .out(o1), .oe(e1), .ext_en(xe[1]),
        .ext_val(xv[1]), .pin(p1));
    qbp_pin_model PM2 (.clk(sys_clk), .out(o2), .oe(e2), .ext_en(xe[2]),
        .ext_val(xv[2]), .pin(p2));
    qbp_pin_model PM3 (.clk(sys_clk), .out(o3), .oe(e3), .ext_en(xe[3]),
        .ext_val(xv[3]), .pin(p3));
    qbp_pin_model #(.W(2)) PM4 (.clk(sys_clk), .out(o4), .oe(e4), .ext_en(xe[4][1:0]),
        .ext_val(xv[4][1:0]), .pin(p4));
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction : xs
    task automatic rnd(output logic [7:0] v);
        seed = xs(seed);
        v = seed[7:0];
    endtask : rnd
    task automatic cmp(input logic [7:0] g, input logic [7:0] e);
        compares++;
        if (g !== e) begin
            fails++;
            $display("Error at %0t got %h exp %h", $time, g, e);
        end
    endtask : cmp
    task automatic tick(input int n);
        repeat (n) @(negedge sys_clk);
    endtask : tick
    task automatic wrp(input int p, input logic [7:0] v);
        adr_s = adr[p];
        wd = v;
        wr = 1'b1;
        tick(1);
        wr = 1'b0;
        lat[p] = v;
        tick(1);
    endtask : wrp
    task automatic bwr(input int p, input logic [2:0] i, input logic v);
        adr_s = adr[p];
        bs = i;
        bv = v;
        bw = 1'b1;
        tick(1);
        bw = 1'b0;
        lat[p][i] = v;
        tick(1);
    endtask : bwr
    // read strobe; valid stands for exactly the cycle after the taking edge
    task automatic rd(input logic [7:0] a, input logic pin, input logic [7:0] e);
        adr_s = a;
        rl = ~pin;
        rp = pin;
        tick(1);
        rl = 1'b0;
        rp = 1'b0;
        cmp({7'h00, rv}, 8'h01);
        cmp(rdat, e);
        tick(1);
        cmp({7'h00, rv}, 8'h00);
    endtask : rd
    task automatic stop_test();
        $display("fails=%0d compares=%0d", fails, compares);
        if (fails == 0 && compares > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : stop_test
    // ----------------------------------------
    // clock, timeout, sequence
    // ----------------------------------------
    initial begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 20000) begin
            fails++;
            stop_test();
        end
    end
    initial begin
        {wr, bw, bv, rl, rp, ext, bs, wd, ea, eh, xe, xv} = '0;
        adr_s = 8'h00;
        {a1, a3, a4} = '1;
        foreach (lat[i]) lat[i] = 255;
        rst_n = 1'b0;
        tick(12);
        rst_n = 1'b1;
        tick(1);
        for (int p = 0; p < 5; p++) rd(adr[p], 1'b0, msk[p]);
        wrp(1, 8'h00);
        adr_s = 8'h81;
        wr = 1'b1;
        tick(1);
        wr = 1'b0;
        rd(8'h81, 1'b0, 8'h00);
        rd(adr[1], 1'b0, 8'h00);
        for (int n = 0; n < 15; n++) begin
            rnd(d);
            wrp(n % 5, d);
            tick(1);
            rd(adr[n % 5], 1'b0, d & msk[n % 5]);
            cmp(e1, ~lat[1][7:0]);
            cmp(t1, lat[1][7:0]);
            cmp(t2, lat[2][7:0]);
            cmp(t3, lat[3][7:0]);
            cmp({6'h00, t4}, {6'h00, lat[4][1:0]});
            cmp(k3, lat[3][7:0]);
            cmp(o1 | o2 | o3, 8'h00);
            cmp(e0, ~lat[0][7:0]);
            cmp(o0, 8'h00);
        end
        for (int n = 0; n < 8; n++) begin
            rnd(d);
            bwr(2, d[2:0], d[3]);
            rd(adr[2], 1'b0, lat[2][7:0]);
        end
        wrp(1, 8'hFF);
        rnd(d);
        xe[1] = 8'hFF;
        xv[1] = d;
        tick(4);
        rd(adr[1], 1'b1, d);
        rd(adr[1], 1'b0, 8'hFF);
        cmp(k1, d);
        xe[1] = 8'h00;
        wrp(3, 8'h00);
        tick(3);
        wrp(3, 8'hA7);
        cmp(b3, 8'hA7);
        tick(1);
        cmp(b3, 8'hA7);
        tick(1);
        cmp(b3, 8'h00);
        rnd(d);
        a3 = d & 8'hFD;
        a4 = d[5:4];
        rnd(a1);
        tick(2);
        cmp(e3, ~(8'hA7 & a3));
        cmp(e1, ~a1);
        cmp({6'h00, e4}, {6'h00, ~(lat[4][1:0] & a4)});
        {a1, a3, a4} = '1;
        rnd(d);
        wrp(0, 8'h0F);
        ext = 1'b1;
        ea = d;
        eh = ~d;
        tick(3);
        cmp(o0, d);
        cmp(e0, 8'hFF);
        cmp(e2, d);
        cmp(b2, ~d);
        ext = 1'b0;
        tick(3);
        cmp(e0, 8'hF0);
        wrp(4, 8'h03);
        xe[4] = 8'h02;
        tick(4);
        cmp({7'h00, can}, 8'h00);
        cmp({6'h00, k4}, 8'h01);
        xe[4] = 8'h00;
        tick(4);
        cmp({7'h00, can}, 8'h01);
        rst_n = 1'b0;
        tick(1);
        rst_n = 1'b1;
        tick(1);
        rd(adr[3], 1'b0, 8'hFF);
        cmp(t1, 8'hFF);
        stop_test();
    end
endmodule : testbench
`default_nettype wire
